// ==== core/scpg_strap_config.sv ====
// strap decoder, strap-loaded configuration registers and payload pattern
`timescale 1ns/10ps
`default_nettype none
module scpg_strap_config (
   input  wire logic                                       clk_sys,
   input  wire logic                                       rst_b,
   input  wire logic [scpg_pkg::STRAP_PINS-1:0]            strap_rail,
   input  wire logic [scpg_pkg::STRAP_PINS*scpg_pkg::LEVEL_W-1:0] strap_level,
   input  wire logic                                       mdc,
   input  wire logic                                       mdio_i,
   output var  logic                                       mdio_o,
   output var  logic                                       mdio_oe_b,
   input  wire logic                                       generator_run,
   output var  logic                                       strap_done,
   output var  logic [4:0]                                 station_address,
   output var  logic [3:0]                                 adv_abil,
   output var  logic [1:0]                                 adv_gig,
   output var  logic                                       adv_asym_pause,
   output var  logic                                       adv_sym_pause,
   output var  logic                                       clock_output_en,
   output var  logic                                       link_power_saving_en,
   output var  logic                                       downshift_en,
   output var  logic [1:0]                                 mac_cal,
   output var  logic [1:0]                                 rx_skew,
   output var  logic [1:0]                                 tx_skew,
   output var  logic [15:0]                                payload,
   output var  logic [15:0]                                payload_pattern
);
   import scpg_pkg::*;

   // pin value from rail and resistor ladder step
   function automatic logic [STRAP_W-1:0] strap_value(input logic rail,
                                                      input logic [LEVEL_W-1:0] level);
      return {rail, level};
   endfunction

   // advertised abilities per speed and duplex code: {gigabit, 10/100}
   function automatic logic [5:0] adv_of(input logic [1:0] code);
      case (code)
         2'h0:    return {GIG_BOTH, ABIL_ALL};
         2'h1:    return {GIG_FULL, ABIL_ALL};
         2'h2:    return {GIG_FULL, ABIL_NONE};
         default: return {GIG_NONE, ABIL_ALL};
      endcase
   endfunction

   // place a field into a 16-bit register word
   function automatic logic [15:0] fld(input logic [15:0] v, input int pos);
      return 16'(v << pos);
   endfunction

   logic [STRAP_PINS-1:0]         rail_s1, rail_s2;
   logic [STRAP_PINS*LEVEL_W-1:0] lvl_s1, lvl_s2;
   logic [CFG_W-1:0]              cfg;
   logic                          ext_page;
   logic                          run_q;
   scpg_mgmt_if                   mg ();

   // strap pins are outside the clock domain: two flops before decoding
   always_ff @(posedge clk_sys) begin
      rail_s1 <= strap_rail;
      rail_s2 <= rail_s1;
      lvl_s1  <= strap_level;
      lvl_s2  <= lvl_s1;
   end

   // per-pin decode
   for (genvar g = 0; g < STRAP_PINS; g++) begin : g_pin
      assign cfg[g*STRAP_W +: STRAP_W] = strap_value(rail_s2[g],
                                                     lvl_s2[g*LEVEL_W +: LEVEL_W]);
   end

   // strap fields
   wire [4:0] strap_addr = {cfg[3*STRAP_W+HI_BIT], cfg[3*STRAP_W+ADDR_BIT],
                            cfg[2*STRAP_W+ADDR_BIT], cfg[STRAP_W+ADDR_BIT], cfg[ADDR_BIT]};
   wire [1:0] strap_cal  = cfg[3*STRAP_W +: 2];
   wire       strap_lps  = cfg[2*STRAP_W+HI_BIT];
   wire [1:0] strap_skew = cfg[2*STRAP_W +: 2];
   wire       strap_down = cfg[STRAP_W+HI_BIT];
   wire [5:0] strap_adv  = adv_of(cfg[STRAP_W +: 2]);
   wire       strap_clko = cfg[HI_BIT];
   wire       strap_asym = cfg[1];
   wire       strap_sym  = cfg[0];
   wire       strap_load = ~strap_done;

   // write decode
   wire [4:0]  wa      = mg.reg_addr;
   wire [15:0] wd      = mg.wr_data;
   wire        wr_std  = mg.wr_stb & ~ext_page;
   wire        wr_ext  = mg.wr_stb & ext_page;
   wire        wr_page = mg.wr_stb & (wa == REG_PAGE);
   wire        wr_adv  = wr_std & (wa == REG_ADV);
   wire        wr_gig  = wr_std & (wa == REG_GIG);
   wire        wr_clko = wr_std & (wa == REG_CLK_OUT);
   wire        wr_lps  = wr_std & (wa == REG_LPS);
   wire        wr_cal  = wr_ext & (wa == EXT_CAL);
   wire        wr_down = wr_ext & (wa == EXT_DOWN);
   wire        wr_skew = wr_ext & (wa == EXT_SKEW);
   wire        wr_pay  = wr_ext & (wa == EXT_PAYLOAD);

   // read selection; unlisted bits read zero
   wire        rd_std  = ~ext_page;
   wire [15:0] w_adv   = fld(16'(adv_asym_pause), ADV_ASYM_BIT) | fld(16'(adv_sym_pause),
                         ADV_SYM_BIT) | fld(16'(adv_abil), ADV_ABIL_LSB);
   wire [15:0] w_skew  = fld(16'(tx_skew), SKEW_TX_LSB) | fld(16'(rx_skew), SKEW_RX_LSB);
   assign mg.rd_data =
        ({16{wa == REG_PAGE}}              & fld(16'(ext_page), PAGE_BIT))
      | ({16{rd_std && wa == REG_ADV}}     & w_adv)
      | ({16{rd_std && wa == REG_GIG}}     & fld(16'(adv_gig), GIG_ABIL_LSB))
      | ({16{rd_std && wa == REG_CLK_OUT}} & fld(16'(clock_output_en), CLK_OUT_BIT))
      | ({16{rd_std && wa == REG_LPS}}     & fld(16'(link_power_saving_en), LPS_BIT))
      | ({16{ext_page && wa == EXT_CAL}}   & fld(16'(mac_cal), CAL_LSB))
      | ({16{ext_page && wa == EXT_DOWN}}  & fld(16'(downshift_en), DOWN_BIT))
      | ({16{ext_page && wa == EXT_SKEW}}  & w_skew)
      | ({16{ext_page && wa == EXT_PAYLOAD}} & payload);
   assign mg.station_address = station_address;

   // management frame engine
   scpg_mdio_slave u_mdio (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .mdc       (mdc),
      .mdio_i    (mdio_i),
      .mdio_o    (mdio_o),
      .mdio_oe_b (mdio_oe_b),
      .mg        (mg)
   );

   // strap capture on the first cycle after reset release; address only from straps
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         strap_done      <= 1'b0;
         station_address <= 5'h00;
      end else if (strap_load) begin
         strap_done      <= 1'b1;
         station_address <= strap_addr;
      end
   end

   // page select
   always_ff @(posedge clk_sys) begin
      if (!rst_b) ext_page <= 1'b0;
      else if (wr_page) ext_page <= wd[PAGE_BIT];
   end

   // advertisement defaults from straps, then management overrides
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         {adv_gig, adv_abil}             <= 6'h00;
         {adv_asym_pause, adv_sym_pause} <= 2'h0;
      end else if (strap_load) begin
         {adv_gig, adv_abil}             <= strap_adv;
         {adv_asym_pause, adv_sym_pause} <= {strap_asym, strap_sym};
      end else begin
         if (wr_adv) begin
            adv_abil       <= wd[ADV_ABIL_LSB +: 4];
            adv_asym_pause <= wd[ADV_ASYM_BIT];
            adv_sym_pause  <= wd[ADV_SYM_BIT];
         end
         if (wr_gig) adv_gig <= wd[GIG_ABIL_LSB +: 2];
      end
   end

   // single-bit enables
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         {clock_output_en, link_power_saving_en, downshift_en} <= 3'h0;
      end else if (strap_load) begin
         clock_output_en      <= strap_clko;
         link_power_saving_en <= strap_lps;
         downshift_en         <= strap_down;
      end else begin
         if (wr_clko) clock_output_en      <= wd[CLK_OUT_BIT];
         if (wr_lps)  link_power_saving_en <= wd[LPS_BIT];
         if (wr_down) downshift_en         <= wd[DOWN_BIT];
      end
   end

   // calibration and clock skew
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         {mac_cal, rx_skew, tx_skew} <= 6'h00;
      end else if (strap_load) begin
         mac_cal <= strap_cal;
         rx_skew <= strap_skew;
         tx_skew <= strap_skew;
      end else begin
         if (wr_cal) mac_cal <= wd[CAL_LSB +: 2];
         if (wr_skew) begin
            tx_skew <= wd[SKEW_TX_LSB +: 2];
            rx_skew <= wd[SKEW_RX_LSB +: 2];
         end
      end
   end

   // payload register and the copy the generator uses, taken at each start
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         payload         <= PAYLOAD_RST;
         payload_pattern <= PAYLOAD_RST;
         run_q           <= 1'b0;
      end else begin
         run_q <= generator_run;
         if (wr_pay) payload <= wd;
         if (generator_run && !run_q) payload_pattern <= payload;
      end
   end

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence s_load;
      strap_load ##1 strap_done;
   endsequence

   a_payload_reset: assert property ($rose(rst_b) |-> payload == PAYLOAD_RST)
      else $error("payload not zero after reset");
   a_payload_write: assert property (wr_pay |=> payload == $past(wd))
      else $error("payload write lost");
   a_pattern_start: assert property (
      $rose(generator_run) |=> payload_pattern == $past(payload))
      else $error("pattern not taken at generator start");
   a_pattern_hold: assert property (run_q && generator_run |=> $stable(payload_pattern))
      else $error("pattern changed while generator running");
   a_pattern_only_start: assert property (
      !$rose(generator_run) |=> $stable(payload_pattern))
      else $error("pattern changed without generator restart");
   a_addr_capture: assert property (strap_load |=> station_address == $past(strap_addr))
      else $error("station address not taken from straps");
   a_addr_fixed: assert property (s_load |=> $stable(station_address) [*8])
      else $error("station address changed after load");
   // speed and duplex code, one property per code so each decode is pinned down
   a_adv_all_speeds: assert property (
      strap_load && cfg[STRAP_W +: 2] == 2'h0 |=> adv_abil == ABIL_ALL && adv_gig == GIG_BOTH)
      else $error("all-speed code mis-decoded");
   a_adv_full_gig: assert property (
      strap_load && cfg[STRAP_W +: 2] == 2'h1 |=> adv_abil == ABIL_ALL && adv_gig == GIG_FULL)
      else $error("gigabit full duplex code mis-decoded");
   a_adv_gig_only: assert property (
      strap_load && cfg[STRAP_W +: 2] == 2'h2 |=> adv_abil == ABIL_NONE && adv_gig == GIG_FULL)
      else $error("gigabit-only code mis-decoded");
   a_adv_no_gig: assert property (
      strap_load && cfg[STRAP_W +: 2] == 2'h3 |=> adv_abil == ABIL_ALL && adv_gig == GIG_NONE)
      else $error("10/100 code mis-decoded");
   // remaining strap defaults, each against its own pin bit
   a_skew_both: assert property (
      strap_load |=> rx_skew == tx_skew && rx_skew == $past(strap_skew))
      else $error("clock skew not applied to both clocks");
   a_cal_map: assert property (strap_load |=> mac_cal == $past(cfg[3*STRAP_W +: 2]))
      else $error("calibration default mismatch");
   a_pause_load: assert property (
      strap_load |=> {adv_asym_pause, adv_sym_pause} == $past(cfg[1:0]))
      else $error("pause advertisement default mismatch");
   a_clko_load: assert property (strap_load |=> clock_output_en == $past(cfg[HI_BIT]))
      else $error("clock output default mismatch");
   a_lps_load: assert property (
      strap_load |=> link_power_saving_en == $past(cfg[2*STRAP_W+HI_BIT]))
      else $error("link power saving default mismatch");
   a_down_load: assert property (
      strap_load |=> downshift_en == $past(cfg[STRAP_W+HI_BIT]))
      else $error("downshift default mismatch");
   a_load_once: assert property (strap_done |=> strap_done && !strap_load)
      else $error("straps reloaded without reset");
   // management overrides land the cycle after the write strobe
   a_clko_write: assert property (
      wr_clko && strap_done |=> clock_output_en == $past(wd[CLK_OUT_BIT]))
      else $error("clock output override lost");
   a_adv_write: assert property (
      wr_adv && strap_done |=> adv_abil == $past(wd[ADV_ABIL_LSB +: 4])
                               && adv_asym_pause == $past(wd[ADV_ASYM_BIT]))
      else $error("advertisement override lost");
   a_gig_write: assert property (
      wr_gig && strap_done |=> adv_gig == $past(wd[GIG_ABIL_LSB +: 2]))
      else $error("gigabit advertisement override lost");
   a_lps_write: assert property (
      wr_lps && strap_done |=> link_power_saving_en == $past(wd[LPS_BIT]))
      else $error("link power saving override lost");
   a_down_write: assert property (
      wr_down && strap_done |=> downshift_en == $past(wd[DOWN_BIT]))
      else $error("downshift override lost");
   a_cal_write: assert property (
      wr_cal && strap_done |=> mac_cal == $past(wd[CAL_LSB +: 2]))
      else $error("calibration override lost");
   a_skew_write: assert property (
      wr_skew && strap_done |=> tx_skew == $past(wd[SKEW_TX_LSB +: 2])
                                && rx_skew == $past(wd[SKEW_RX_LSB +: 2]))
      else $error("clock skew override lost");
   a_addr_no_write: assert property (
      mg.wr_stb && strap_done |=> $stable(station_address))
      else $error("station address written by management");
endmodule
`default_nettype wire

// ==== core/scpg_pkg.sv ====
// constants and types shared by the strap loader and its management port
package scpg_pkg;
   // strap pins and their decoded value
   localparam int STRAP_PINS = 4;
   localparam int STRAP_W    = 4;
   localparam int LEVEL_W    = 3;
   localparam int CFG_W      = STRAP_PINS * STRAP_W;
   localparam int ADDR_BIT   = 3;                  // bit 3 of each pin: address
   localparam int HI_BIT     = 2;                  // bit 2 of each pin
   // management register addresses, standard page
   localparam logic [4:0] REG_ADV     = 5'h04;
   localparam logic [4:0] REG_GIG     = 5'h09;
   localparam logic [4:0] REG_CLK_OUT = 5'h12;
   localparam logic [4:0] REG_LPS     = 5'h17;
   localparam logic [4:0] REG_PAGE    = 5'h1f;
   // management register addresses, extended page
   localparam logic [4:0] EXT_CAL     = 5'h13;
   localparam logic [4:0] EXT_DOWN    = 5'h14;
   localparam logic [4:0] EXT_SKEW    = 5'h1c;
   localparam logic [4:0] EXT_PAYLOAD = 5'h1e;
   // field positions
   localparam int ADV_ASYM_BIT = 11;
   localparam int ADV_SYM_BIT  = 10;
   localparam int ADV_ABIL_LSB = 5;
   localparam int GIG_ABIL_LSB = 8;
   localparam int CLK_OUT_BIT  = 0;
   localparam int LPS_BIT      = 5;
   localparam int CAL_LSB      = 14;
   localparam int DOWN_BIT     = 4;
   localparam int SKEW_TX_LSB  = 14;
   localparam int SKEW_RX_LSB  = 12;
   localparam int PAGE_BIT     = 0;
   // reset values
   localparam logic [15:0] PAYLOAD_RST = 16'h0000;
   // advertised abilities: 100 full, 100 half, 10 full, 10 half
   localparam logic [3:0] ABIL_ALL  = 4'hf;
   localparam logic [3:0] ABIL_NONE = 4'h0;
   // gigabit abilities: full, half
   localparam logic [1:0] GIG_BOTH  = 2'h3;
   localparam logic [1:0] GIG_FULL  = 2'h2;
   localparam logic [1:0] GIG_NONE  = 2'h0;
   // management frame
   localparam logic [5:0] PRE_LEN = 6'h20;
   localparam logic [5:0] HDR_LEN = 6'h0e;
   localparam logic [5:0] DATA_W  = 6'h10;
   localparam logic [1:0] FR_ST   = 2'h1;
   localparam logic [1:0] OP_RD   = 2'h2;
   localparam logic [1:0] OP_WR   = 2'h1;
   typedef enum logic [1:0] {MD_PRE, MD_HDR, MD_TURN, MD_DATA} scpg_mdio_st_t;
endpackage

// ==== core/scpg_mgmt_if.sv ====
// register access path between the serial management engine and the registers
`timescale 1ns/10ps
`default_nettype none
interface scpg_mgmt_if;
   logic [4:0]  reg_addr;
   logic        wr_stb;
   logic [15:0] wr_data;
   logic [15:0] rd_data;
   logic [4:0]  station_address;
   modport slave (output reg_addr, output wr_stb, output wr_data,
                  input rd_data, input station_address);
   modport regs  (input reg_addr, input wr_stb, input wr_data,
                  output rd_data, output station_address);
endinterface
`default_nettype wire

// ==== core/scpg_mdio_slave.sv ====
// serial management frame engine: preamble, header, turnaround, data
`timescale 1ns/10ps
`default_nettype none
module scpg_mdio_slave (
   input  wire logic     clk_sys,
   input  wire logic     rst_b,
   input  wire logic     mdc,
   input  wire logic     mdio_i,
   output var  logic     mdio_o,
   output var  logic     mdio_oe_b,
   scpg_mgmt_if.slave    mg
);
   import scpg_pkg::*;

   logic          mdc_s1, mdc_s2, mdc_s3, dio_s1, dio_s2;
   scpg_mdio_st_t state;
   logic [5:0]    cnt;
   logic [13:0]   hdr;
   logic [15:0]   sh;
   logic          is_rd;
   logic [4:0]    reg_addr;
   logic          wr_stb;

   // two-flop synchronisers, third stage only for the clock edge
   always_ff @(posedge clk_sys) begin
      mdc_s1 <= mdc;
      mdc_s2 <= mdc_s1;
      mdc_s3 <= mdc_s2;
      dio_s1 <= mdio_i;
      dio_s2 <= dio_s1;
   end

   // header decode on the bit being shifted in
   wire        rise     = mdc_s2 & ~mdc_s3;
   wire [13:0] next_hdr = {hdr[12:0], dio_s2};
   wire [1:0]  hdr_op   = next_hdr[11:10];
   wire        frame_ok = (next_hdr[13:12] == FR_ST) && (hdr_op == OP_RD || hdr_op == OP_WR)
                          && (next_hdr[9:5] == mg.station_address);
   assign mg.reg_addr = reg_addr;
   assign mg.wr_stb   = wr_stb;
   assign mg.wr_data  = sh;

   // frame sequencer, one step per rising management clock edge
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state     <= MD_PRE;
         cnt       <= 6'h00;
         hdr       <= 14'h0000;
         sh        <= 16'h0000;
         is_rd     <= 1'b0;
         reg_addr  <= 5'h00;
         wr_stb    <= 1'b0;
         mdio_o    <= 1'b0;
         mdio_oe_b <= 1'b1;
      end else begin
         wr_stb <= 1'b0;
         if (rise) begin
            case (state)
               MD_PRE: begin
                  if (dio_s2) begin
                     cnt <= (cnt == PRE_LEN) ? cnt : cnt + 6'h01;
                  end else if (cnt == PRE_LEN) begin
                     state <= MD_HDR;
                     hdr   <= next_hdr;
                     cnt   <= 6'h01;
                  end else begin
                     cnt <= 6'h00;
                  end
               end
               MD_HDR: begin
                  hdr <= next_hdr;
                  cnt <= cnt + 6'h01;
                  if (cnt == HDR_LEN - 6'h01) begin
                     cnt      <= 6'h00;
                     state    <= frame_ok ? MD_TURN : MD_PRE;
                     reg_addr <= next_hdr[4:0];
                     is_rd    <= (hdr_op == OP_RD);
                  end
               end
               MD_TURN: begin
                  cnt <= cnt + 6'h01;
                  if (is_rd) begin
                     mdio_oe_b <= 1'b0;       // drive the second turnaround bit low
                     mdio_o    <= 1'b0;
                     sh        <= mg.rd_data;
                     state     <= MD_DATA;
                     cnt       <= 6'h00;
                  end else if (cnt == 6'h01) begin
                     state <= MD_DATA;
                     cnt   <= 6'h00;
                  end
               end
               MD_DATA: begin
                  cnt <= cnt + 6'h01;
                  if (is_rd) begin
                     if (cnt == DATA_W) begin
                        mdio_oe_b <= 1'b1;
                        state     <= MD_PRE;
                        cnt       <= 6'h00;
                     end else begin
                        mdio_o <= sh[15];
                        sh     <= {sh[14:0], 1'b0};
                     end
                  end else begin
                     sh <= {sh[14:0], dio_s2};
                     if (cnt == DATA_W - 6'h01) begin
                        wr_stb <= 1'b1;
                        state  <= MD_PRE;
                        cnt    <= 6'h00;
                     end
                  end
               end
               default: state <= MD_PRE;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ==== testbench/scpg_mgmt_station.sv ====
// management station on the serial pins, with the wire pull-up
`timescale 1ns/10ps
`default_nettype none
module scpg_mgmt_station (
   input  wire logic clk_sys,
   output var  logic mdc,
   output wire logic mdio_i,
   input  wire logic mdio_o,
   input  wire logic mdio_oe_b
);
   logic drv;
   // open-drain wire: low when either party pulls it low, else pulled up
   assign mdio_i = drv & (mdio_oe_b | mdio_o);
   // clock stands low and wire released outside frames
   initial begin
      mdc = 1'b0;
      drv = 1'b1;
   end
   // one bit: data set while clock low, wire sampled as the clock rises
   task automatic bit_cyc(input logic b, output logic s);
      @(posedge clk_sys) #1;
      mdc = 1'b0;
      drv = b;
      repeat (5) @(posedge clk_sys);
      #1 s = mdio_i;
      mdc = 1'b1;
      repeat (5) @(posedge clk_sys);
   endtask
   // full frame with its own preamble; a read releases the wire after the header
   task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
      logic        s;
      logic [31:0] f;
      f = (op == 2'b10) ? {2'b01, op, pa, ra, 18'h3ffff} : {2'b01, op, pa, ra, 2'b10, wd};
      for (int i = 0; i < 32; i++) bit_cyc(1'b1, s);
      for (int i = 31; i >= 0; i--) begin
         bit_cyc(f[i], s);
         if (i < 16) rd[i] = s;
      end
      @(posedge clk_sys) #1;
      mdc = 1'b0;
      drv = 1'b1;
      repeat (10) @(posedge clk_sys);
   endtask
endmodule
`default_nettype wire

// ==== testbench/scpg_strap_config_tb.sv ====
// self-checking bench for the strap loader and payload pattern register
`timescale 1ns/10ps
`default_nettype none
module scpg_strap_config_tb;
   import scpg_pkg::*;
   logic        clk_sys, rst_b, generator_run, mdc, mdio_i, mdio_o, mdio_oe_b, strap_done;
   logic [3:0]  strap_rail, adv_abil;
   logic [11:0] strap_level;
   logic [4:0]  station_address, sa;
   logic [1:0]  adv_gig, mac_cal, rx_skew, tx_skew;
   logic        adv_asym_pause, adv_sym_pause, clock_output_en;
   logic        link_power_saving_en, downshift_en;
   logic [15:0] payload, payload_pattern, rd, pat, s;
   logic [3:0]  p [4];
   int          num_errors, total_checks;

   scpg_strap_config u_dut (.clk_sys, .rst_b, .strap_rail, .strap_level, .mdc, .mdio_i,
      .mdio_o, .mdio_oe_b, .generator_run, .strap_done, .station_address, .adv_abil,
      .adv_gig, .adv_asym_pause, .adv_sym_pause, .clock_output_en, .link_power_saving_en,
      .downshift_en, .mac_cal, .rx_skew, .tx_skew, .payload, .payload_pattern);
   scpg_mgmt_station u_sta (.clk_sys, .mdc, .mdio_i, .mdio_o, .mdio_oe_b);

   // 100 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // hang guard
   initial begin
      repeat (100000) @(posedge clk_sys);
      num_errors++;
      conclude();
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // reference decode of the pins, compared with every configuration output
   task automatic check_straps();
      logic [5:0] ab;
      for (int g = 0; g < 4; g++) p[g] = {strap_rail[g], strap_level[3*g +: 3]};
      case (p[1][1:0])
         2'h0: ab = {ABIL_ALL, GIG_BOTH};
         2'h1: ab = {ABIL_ALL, GIG_FULL};
         2'h2: ab = {ABIL_NONE, GIG_FULL};
         default: ab = {ABIL_ALL, GIG_NONE};
      endcase
      sa = {p[3][2], p[3][3], p[2][3], p[1][3], p[0][3]};
      chk({11'h0, station_address}, {11'h0, sa});
      chk({10'h0, adv_abil, adv_gig}, {10'h0, ab});
      chk({12'h0, mac_cal, downshift_en, link_power_saving_en},
          {12'h0, p[3][1:0], p[1][2], p[2][2]});
      chk({12'h0, rx_skew, tx_skew}, {12'h0, p[2][1:0], p[2][1:0]});
      chk({13'h0, clock_output_en, adv_asym_pause, adv_sym_pause}, {13'h0, p[0][2:0]});
      chk(payload, PAYLOAD_RST);
      chk({15'h0, strap_done}, 16'h0001);
   endtask

   // reset with straps set from its start, then release and compare
   task automatic do_reset(input int n, input logic [15:0] v);
      @(posedge clk_sys) #1;
      rst_b = 1'b0;
      {strap_rail, strap_level} = v;
      repeat (n) @(posedge clk_sys);
      #1 chk({15'h0, strap_done}, 16'h0000);
      rst_b = 1'b1;
      @(posedge clk_sys) #1;
      check_straps();
   endtask

   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      u_sta.frame(OP_WR, sa, ra, d, rd);
   endtask

   task automatic rd_chk(input logic [4:0] ra, input logic [15:0] e);
      u_sta.frame(OP_RD, sa, ra, 16'h0000, rd);
      chk(rd, e);
   endtask

   // straps over all codes, then management overrides and the payload path
   initial begin
      rst_b = 1'b0;
      generator_run = 1'b0;
      strap_rail = 4'h0;
      strap_level = 12'h000;
      void'($urandom(34715));
      do_reset(10, 16'h0000);
      do_reset(4, 16'hffff);
      for (int k = 0; k < 16; k++) begin
         s = 16'($urandom());
         s[4:3] = k[1:0];
         s[7:6] = k[3:2];
         s[10:9] = k[1:0];
         do_reset(4, s);
      end
      pat = 16'($urandom());
      wr(REG_ADV, pat);
      wr(REG_GIG, pat);
      chk({4'h0, adv_asym_pause, adv_sym_pause, adv_abil, adv_gig, 4'h0},
          {4'h0, pat[11:10], pat[8:5], pat[9:8], 4'h0});
      rd_chk(REG_ADV, {4'h0, pat[11:10], 1'b0, pat[8:5], 5'h00});
      wr(REG_CLK_OUT, pat);
      wr(REG_LPS, ~pat);
      chk({14'h0, clock_output_en, link_power_saving_en}, {14'h0, pat[0], ~pat[5]});
      // a frame for another station must be ignored
      u_sta.frame(OP_WR, sa ^ 5'h01, REG_CLK_OUT, ~pat, rd);
      chk({15'h0, clock_output_en}, {15'h0, pat[0]});
      rd_chk(5'h02, 16'h0000);
      wr(REG_PAGE, 16'h0001);
      rd_chk(EXT_PAYLOAD, PAYLOAD_RST);
      wr(EXT_CAL, pat);
      wr(EXT_DOWN, pat);
      wr(EXT_SKEW, ~pat);
      chk({9'h0, mac_cal, downshift_en, tx_skew, rx_skew},
          {9'h0, pat[15:14], pat[4], ~pat[15:12]});
      // new pattern waits for a generator restart
      wr(EXT_PAYLOAD, pat);
      chk(payload_pattern, PAYLOAD_RST);
      @(posedge clk_sys) #1 generator_run = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 chk(payload_pattern, pat);
      wr(EXT_PAYLOAD, ~pat);
      chk(payload, ~pat);
      chk(payload_pattern, pat);
      @(posedge clk_sys) #1 generator_run = 1'b0;
      @(posedge clk_sys) #1 generator_run = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 chk(payload_pattern, ~pat);
      rd_chk(EXT_PAYLOAD, ~pat);
      chk({11'h0, station_address}, {11'h0, sa});
      conclude();
   end
endmodule
`default_nettype wire
